// *** sim/wdt_timer_bench.sv ***
// self-checking bench for the watchdog timer top
`timescale 1ns/1ps
module wdt_timer_bench;

    // ****************************************
    // signals and counters
    // ****************************************
    localparam int unsigned SIM_DIV = 32; // short long-ratio keeps the run brief
    // cycles from reset to the first overflow with the reset configuration
    localparam int unsigned DEF_CYCLES = (wdt_pkg::CNT_MAX - wdt_pkg::RELOAD_RST + 32'h00000001)
        * wdt_pkg::FAST_DIV;
    logic clk = 1'b0; // 40 MHz system clock
    logic sysRst = 1'b1; // held for 10 cycles at start
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic irq;
    logic resetReq;
    int errCount = 0; // mismatches seen
    int numChecks = 0; // comparisons made
    logic [31:0] rd; // last read word
    logic er; // last error flag
    int n; // cycle counter for waits

    // one table row: access, expected read word and error flag
    typedef struct {
        logic [7:0] addr;
        logic wr;
        logic [31:0] wdat;
        logic [31:0] exp;
        logic err;
    } wdt_row_type;
    wdt_row_type rows [0:13] = '{
        '{wdt_pkg::OFS_COUNT, 1'b0, 32'h0, 32'h0001FF02, 1'b0},
        '{wdt_pkg::OFS_CTRL, 1'b0, 32'h0, 32'h00000000, 1'b0},
        '{wdt_pkg::OFS_RELOAD, 1'b0, 32'h0, 32'h0000FF02, 1'b0},
        '{wdt_pkg::OFS_IRQ_ENABLE, 1'b0, 32'h0, 32'h00000001, 1'b0},
        '{wdt_pkg::OFS_IRQ_STATUS, 1'b0, 32'h0, 32'h00000000, 1'b0},
        '{wdt_pkg::OFS_SERVICE, 1'b0, 32'h0, 32'h00000000, 1'b0},
        '{wdt_pkg::OFS_COMMAND, 1'b0, 32'h0, 32'h00000000, 1'b0},
        '{wdt_pkg::OFS_IRQ_CLEAR, 1'b0, 32'h0, 32'h00000000, 1'b0},
        '{wdt_pkg::OFS_RELOAD, 1'b1, 32'h0000FFF0, 32'h0, 1'b0},
        '{wdt_pkg::OFS_RELOAD, 1'b0, 32'h0, 32'h0000FFF0, 1'b0},
        '{wdt_pkg::OFS_CTRL, 1'b1, 32'h00000001, 32'h0, 1'b0},
        '{wdt_pkg::OFS_CTRL, 1'b0, 32'h0, 32'h00000001, 1'b0},
        '{8'h20, 1'b0, 32'h0, 32'h00000000, 1'b1},
        '{8'h24, 1'b1, 32'h0000FFFF, 32'h0, 1'b1}
    };

    // ****************************************
    // clock and device
    // ****************************************
    always #12.5 clk = ~clk;

    wdt_timer #(.SLOW_DIV(SIM_DIV)) i_wdt_timer (
        .clk(clk),
        .sys_rst(sysRst),
        .psel(psel),
        .penable(penable),
        .pwrite(pwrite),
        .paddr(paddr),
        .pwdata(pwdata),
        .prdata(prdata),
        .pready(pready),
        .pslverr(pslverr),
        .irq(irq),
        .resetReq(resetReq)
    );

    // ****************************************
    // tasks
    // ****************************************
    // verdict in one place for normal end and watchdog
    task automatic complete_run();
        if (errCount == 0 && numChecks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    // compare a seen word with the expected one
    task automatic check(input string what, input logic [31:0] got, input logic [31:0] exp);
        numChecks++;
        if (got !== exp) begin
            errCount++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask

    // one apb transfer; request held until pready is seen at an edge
    task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        paddr <= a;
        pwrite <= w;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        // pready may stretch the access phase; only the bench watchdog ends a wait
        while (pready !== 1'b1) begin
            @(posedge clk);
        end
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    // ****************************************
    // watchdog against a hang
    // ****************************************
    initial begin
        repeat (DEF_CYCLES + 32'h00004E20) @(posedge clk); // longest scenario plus margin
        errCount++;
        complete_run();
    end

    // ****************************************
    // main sequence
    // ****************************************
    initial begin
        repeat (10) @(posedge clk);
        sysRst <= 1'b0;
        // table of ordinary accesses
        foreach (rows[i]) begin
            apb(rows[i].addr, rows[i].wr, rows[i].wdat);
            check("slverr", {31'h0, er}, {31'h0, rows[i].err});
            check("pready", {31'h0, pready}, 32'h00000001);
            if (!rows[i].wr) begin
                check("rdata", rd, rows[i].exp);
            end
        end
        // service loads the reload value and slow ratio
        apb(wdt_pkg::OFS_SERVICE, 1'b1, 32'h1);
        apb(wdt_pkg::OFS_COUNT, 1'b0, 32'h0);
        check("count after service", rd, 32'h0001FFF0);
        // disable freezes the counter, enable restarts it
        apb(wdt_pkg::OFS_COMMAND, 1'b1, 32'h1);
        apb(wdt_pkg::OFS_COUNT, 1'b0, 32'h0);
        check("count stopped", rd, 32'h0000FFF0);
        repeat (3 * SIM_DIV) @(posedge clk);
        apb(wdt_pkg::OFS_COUNT, 1'b0, 32'h0);
        check("count still stopped", rd, 32'h0000FFF0);
        // both instruction bits at once: disable wins, counter stays stopped
        apb(wdt_pkg::OFS_COMMAND, 1'b1, 32'h00000003);
        apb(wdt_pkg::OFS_COUNT, 1'b0, 32'h0);
        check("both bits", rd, 32'h0000FFF0);
        apb(wdt_pkg::OFS_COMMAND, 1'b1, 32'h2);
        apb(wdt_pkg::OFS_COUNT, 1'b0, 32'h0);
        check("count running", rd, 32'h0001FFF0);
        // two slow ticks to overflow
        apb(wdt_pkg::OFS_RELOAD, 1'b1, 32'h0000FFFE);
        apb(wdt_pkg::OFS_SERVICE, 1'b1, 32'h1);
        n = 0;
        while (irq !== 1'b1 && n < 4 * SIM_DIV) begin
            @(negedge clk);
            n++;
        end
        check("prewarning", {31'h0, irq}, 32'h1);
        repeat (wdt_pkg::PREWARN_CYCLES - 1) @(negedge clk);
        check("request early", {31'h0, resetReq}, 32'h0);
        @(negedge clk);
        check("request", {31'h0, resetReq}, 32'h1);
        // a service now is refused and flagged
        apb(wdt_pkg::OFS_SERVICE, 1'b1, 32'h1);
        apb(wdt_pkg::OFS_IRQ_STATUS, 1'b0, 32'h0);
        check("status", rd, 32'h00000003);
        apb(wdt_pkg::OFS_COUNT, 1'b0, 32'h0);
        check("count halted", rd, 32'h0002FFFE);
        // mask, unmask and clear the interrupt
        apb(wdt_pkg::OFS_IRQ_ENABLE, 1'b1, 32'h0);
        @(negedge clk);
        check("irq masked", {31'h0, irq}, 32'h0);
        apb(wdt_pkg::OFS_IRQ_ENABLE, 1'b1, 32'h3);
        @(negedge clk);
        check("irq unmasked", {31'h0, irq}, 32'h1);
        apb(wdt_pkg::OFS_IRQ_CLEAR, 1'b1, 32'h3);
        @(negedge clk);
        check("irq cleared", {31'h0, irq}, 32'h0);
        apb(wdt_pkg::OFS_IRQ_STATUS, 1'b0, 32'h0);
        check("status cleared", rd, 32'h0);
        // second reset in mid-run restores defaults and running
        @(posedge clk);
        sysRst <= 1'b1;
        repeat (10) @(posedge clk);
        sysRst <= 1'b0;
        @(negedge clk);
        check("request gone", {30'h0, resetReq, irq}, 32'h0);
        // default interval: reload value up to wrap, short ratio
        n = 0;
        while (irq !== 1'b1 && n < 70000) begin
            @(negedge clk);
            n++;
        end
        check("default interval", n, DEF_CYCLES);
        complete_run();
    end

endmodule

// *** src/wdt_core.sv ***
// prescaler and 16-bit up-counter of the watchdog timer
`timescale 1ns/1ps
module wdt_core #(
    parameter int unsigned SLOW_DIV = wdt_pkg::SLOW_DIV_DEF
) (
    // clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // control side
    wdt_core_if.core bus
);

    // ****************************************
    // state
    // ****************************************
    logic [13:0] presc_reg; // prescaler, cleared by service
    logic activeSlow_reg; // ratio in force until next service
    logic [15:0] count_reg; // watchdog counter
    logic [13:0] gap_reg; // helper: cycles counted since last tick

    // terminal prescaler value for a ratio
    function automatic logic [13:0] prescTerminal(input logic slow);
        prescTerminal = slow ? 14'(SLOW_DIV - 1) : 14'(wdt_pkg::FAST_DIV - 1);
    endfunction

    assign bus.tick = bus.run && (presc_reg == prescTerminal(activeSlow_reg));
    assign bus.overflow = bus.tick && (count_reg == wdt_pkg::CNT_MAX);
    assign bus.count = count_reg;

    // prescaler: frozen while stopped, restarts from zero on service
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            presc_reg <= 14'h0000;
        end else if (bus.service) begin
            presc_reg <= 14'h0000;
        end else if (bus.tick) begin
            presc_reg <= 14'h0000;
        end else if (bus.run) begin
            presc_reg <= presc_reg + 14'h0001;
        end
    end

    // ratio change waits for a service so a running interval is not cut short
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            activeSlow_reg <= wdt_pkg::RATIO_RST;
        end else if (bus.service) begin
            activeSlow_reg <= bus.ratioSlow;
        end
    end

    // counter: reloads on service and on wrap
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            count_reg <= wdt_pkg::RELOAD_RST;
        end else if (bus.service) begin
            count_reg <= bus.reload;
        end else if (bus.overflow) begin
            count_reg <= bus.reload;
        end else if (bus.tick) begin
            count_reg <= count_reg + 16'h0001;
        end
    end

    // helper for the tick spacing check only
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            gap_reg <= 14'h0000;
        end else if (bus.service || bus.tick) begin
            gap_reg <= 14'h0000;
        end else if (bus.run) begin
            gap_reg <= gap_reg + 14'h0001;
        end
    end

    // ****************************************
    // checks
    // ****************************************
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);

    a_tick_spacing: assert property (bus.tick |-> gap_reg == prescTerminal(activeSlow_reg))
        else $error("tick spacing differs from the ratio");
    a_count_step: assert property (bus.tick && !bus.service && count_reg != wdt_pkg::CNT_MAX
        |=> count_reg == $past(count_reg) + 16'h0001)
        else $error("counter did not advance by one");
    a_presc_clear: assert property (bus.service |=> presc_reg == 14'h0000 && !bus.tick)
        else $error("prescaler not cleared by service");
    a_reload_load: assert property (bus.service |=> count_reg == $past(bus.reload))
        else $error("service did not load the reload value");
    a_ratio_deferred: assert property ($changed(activeSlow_reg) |-> $past(bus.service))
        else $error("ratio changed without a service");

endmodule

// *** src/wdt_core_if.sv ***
// signals between the watchdog control logic and its counting core
`timescale 1ns/1ps
interface wdt_core_if;
    logic run; // counting allowed
    logic service; // one-cycle reload strobe
    logic ratioSlow; // pending ratio, taken on service
    logic [15:0] reload; // pending reload value
    logic [15:0] count; // live counter
    logic tick; // prescaler terminal
    logic overflow; // one-cycle wrap pulse

    modport ctrl (output run, service, ratioSlow, reload, input count, tick, overflow);
    modport core (input run, service, ratioSlow, reload, output count, tick, overflow);
endinterface

// *** src/wdt_pkg.sv ***
// constants, register map and types shared by the watchdog timer files
package wdt_pkg;

    // ****************************************
    // clock and timing
    // ****************************************
    localparam int unsigned CLK_HZ = 40_000_000; // system clock rate
    localparam int unsigned CLK_PERIOD_NS = 25; // one system clock period
    localparam int unsigned PREWARN_TIME_NS = 1000; // least warning time before reset
    // least time, so round up to whole cycles
    localparam int unsigned PREWARN_CYCLES = (PREWARN_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned PW_CNT_W = 6; // width of the warning counter

    // ****************************************
    // prescaler and counter
    // ****************************************
    localparam int unsigned FAST_DIV = 256; // short ratio
    localparam int unsigned SLOW_DIV_DEF = 16384; // long ratio, top parameter default
    localparam int unsigned PRESC_W = 14; // prescaler width, holds up to 16383
    localparam int unsigned CNT_W = 16; // watchdog counter width
    localparam logic [15:0] CNT_MAX = 16'hFFFF; // last count before overflow
    // 254 fast ticks: about 6.5 ms at a 10 MHz system clock
    localparam logic [15:0] RELOAD_RST = 16'hFF02;
    localparam logic RATIO_RST = 1'b0; // 0 selects the short ratio

    // ****************************************
    // register map, byte addresses
    // ****************************************
    localparam int unsigned ADDR_W = 8;
    localparam logic [7:0] OFS_CTRL = 8'h00; // ratio select
    localparam logic [7:0] OFS_RELOAD = 8'h04; // reload value
    localparam logic [7:0] OFS_SERVICE = 8'h08; // any write services
    localparam logic [7:0] OFS_COMMAND = 8'h0C; // enable and disable instructions
    localparam logic [7:0] OFS_COUNT = 8'h10; // live count and state
    localparam logic [7:0] OFS_IRQ_STATUS = 8'h14; // sticky events, read only
    localparam logic [7:0] OFS_IRQ_CLEAR = 8'h18; // write one to clear
    localparam logic [7:0] OFS_IRQ_ENABLE = 8'h1C; // event mask

    // ****************************************
    // field positions and reset values
    // ****************************************
    localparam int unsigned CTRL_RATIO_BIT = 0; // 1 selects the long ratio
    localparam int unsigned CMD_DISABLE_INSTR_BIT = 0; // watchdog_disable_instr
    localparam int unsigned CMD_ENABLE_INSTR_BIT = 1; // watchdog_enable_instr
    localparam int unsigned COUNT_RUN_BIT = 16; // counter running
    localparam int unsigned COUNT_RESREQ_BIT = 17; // reset request raised
    localparam int unsigned IRQ_W = 2;
    localparam int unsigned IRQ_PREWARN_BIT = 0; // counter overflowed
    localparam int unsigned IRQ_REFUSED_BIT = 1; // service refused after overflow
    localparam logic [1:0] IRQ_ENABLE_RST = 2'h1; // prewarning on by default

    // ****************************************
    // control states
    // ****************************************
    typedef enum logic [1:0] {
        ST_RUN,
        ST_STOP,
        ST_PREWARN,
        ST_RESREQ
    } wdt_state_type;

endpackage

// *** src/wdt_timer.sv ***
// watchdog timer top: APB registers, run control, prewarning and reset request
// Overview of operation
// - counter runs enabled after every reset
// - disable and enable instructions stop, restart counting
// - overflow gives prewarning interrupt, then reset request
// - 16-bit counter ticks at clock/16384 or /256
// - counter loads from programmable reload value
// - service reloads counter and clears prescaler
// - intervals span 6.4 us to 26.8 s at 40 MHz
// - reset defaults give about 6.5 ms at 10 MHz
`timescale 1ns/1ps
module wdt_timer #(
    parameter int unsigned SLOW_DIV = wdt_pkg::SLOW_DIV_DEF // long prescaler ratio
) (
    // clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // system side
    output logic irq,
    output logic resetReq
);

    // ****************************************
    // declarations
    // ****************************************
    localparam int PW_N = int'(wdt_pkg::PREWARN_CYCLES); // cycles from overflow to reset request

    wdt_core_if coreBus(); // link to the counting core

    logic ratioSlow_reg; // software ratio select
    logic [15:0] reloadValue_reg; // software reload value
    logic [1:0] irqStatus_reg; // sticky events
    logic [1:0] irqStatus_next;
    logic [1:0] irqEnable_reg; // event mask
    wdt_pkg::wdt_state_type state_reg; // run control
    wdt_pkg::wdt_state_type state_next;
    logic [5:0] pwCnt_reg; // cycles spent in prewarning
    logic resetReq_reg; // reset request, held until system reset
    logic [31:0] prdata_reg; // read data captured in setup phase

    logic wrAccess; // write taken at this edge
    logic svcWrite; // service register written
    logic disInstr; // disable instruction executed
    logic enInstr; // enable instruction executed
    logic warnDone; // last prewarning cycle
    logic [1:0] irqSet; // events this cycle
    logic [1:0] irqClr; // clears this cycle

    // ****************************************
    // bus decode
    // ****************************************
    // write strobe for one register
    function automatic logic wrHit(input logic en, input logic [7:0] a, input logic [7:0] ofs);
        wrHit = en && (a == ofs);
    endfunction

    // every offset of the map, write-only ones included
    function automatic logic isMapped(input logic [7:0] a);
        case (a)
            wdt_pkg::OFS_CTRL, wdt_pkg::OFS_RELOAD, wdt_pkg::OFS_SERVICE,
            wdt_pkg::OFS_COMMAND, wdt_pkg::OFS_COUNT, wdt_pkg::OFS_IRQ_STATUS,
            wdt_pkg::OFS_IRQ_CLEAR, wdt_pkg::OFS_IRQ_ENABLE: isMapped = 1'b1;
            default: isMapped = 1'b0;
        endcase
    endfunction

    // zero wait states; unmapped addresses answer with an error and no effect
    assign pready = 1'b1;
    assign pslverr = psel && penable && !isMapped(paddr);
    assign wrAccess = psel && penable && pwrite && isMapped(paddr);
    assign prdata = prdata_reg;

    assign svcWrite = wrHit(wrAccess, paddr, wdt_pkg::OFS_SERVICE);
    assign disInstr = wrHit(wrAccess, paddr, wdt_pkg::OFS_COMMAND)
        && pwdata[wdt_pkg::CMD_DISABLE_INSTR_BIT];
    assign enInstr = wrHit(wrAccess, paddr, wdt_pkg::OFS_COMMAND)
        && pwdata[wdt_pkg::CMD_ENABLE_INSTR_BIT];

    // ****************************************
    // configuration registers
    // ****************************************
    // ratio only reaches the counter on the next service, reload on the next service or wrap
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            ratioSlow_reg <= wdt_pkg::RATIO_RST;
            reloadValue_reg <= wdt_pkg::RELOAD_RST;
        end else begin
            if (wrHit(wrAccess, paddr, wdt_pkg::OFS_CTRL)) begin
                ratioSlow_reg <= pwdata[wdt_pkg::CTRL_RATIO_BIT];
            end
            if (wrHit(wrAccess, paddr, wdt_pkg::OFS_RELOAD)) begin
                reloadValue_reg <= pwdata[15:0];
            end
        end
    end

    // interrupt mask
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            irqEnable_reg <= wdt_pkg::IRQ_ENABLE_RST;
        end else if (wrHit(wrAccess, paddr, wdt_pkg::OFS_IRQ_ENABLE)) begin
            irqEnable_reg <= pwdata[1:0];
        end
    end

    // ****************************************
    // core hookup
    // ****************************************
    // a service after overflow is refused: the reset request is committed
    assign coreBus.run = (state_reg == wdt_pkg::ST_RUN);
    assign coreBus.service = svcWrite && (state_reg == wdt_pkg::ST_RUN
        || state_reg == wdt_pkg::ST_STOP);
    assign coreBus.ratioSlow = ratioSlow_reg;
    assign coreBus.reload = reloadValue_reg;

    wdt_core #(
        .SLOW_DIV(SLOW_DIV)
    ) i_wdt_core (
        .clk(clk),
        .sys_rst(sys_rst),
        .bus(coreBus.core)
    );

    // ****************************************
    // run control
    // ****************************************
    assign warnDone = (pwCnt_reg == 6'(PW_N - 1));

    // next state; overflow beats a disable in the same cycle to stay fail-safe
    always_comb begin
        state_next = state_reg;
        case (state_reg)
            wdt_pkg::ST_RUN: begin
                if (coreBus.overflow) begin
                    state_next = wdt_pkg::ST_PREWARN;
                end else if (disInstr) begin
                    state_next = wdt_pkg::ST_STOP;
                end
            end
            wdt_pkg::ST_STOP: begin
                // disable wins if both bits are written together
                if (enInstr && !disInstr) begin
                    state_next = wdt_pkg::ST_RUN;
                end
            end
            wdt_pkg::ST_PREWARN: begin
                if (warnDone) begin
                    state_next = wdt_pkg::ST_RESREQ;
                end
            end
            wdt_pkg::ST_RESREQ: begin
                state_next = wdt_pkg::ST_RESREQ; // only a system reset leaves
            end
            default: begin
                state_next = wdt_pkg::ST_RUN;
            end
        endcase
    end

    // state register; reset lands in counting without software help
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            state_reg <= wdt_pkg::ST_RUN;
        end else begin
            state_reg <= state_next;
        end
    end

    // warning time counter
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            pwCnt_reg <= 6'h00;
        end else if (state_reg != wdt_pkg::ST_PREWARN) begin
            pwCnt_reg <= 6'h00;
        end else if (!warnDone) begin
            pwCnt_reg <= pwCnt_reg + 6'h01;
        end
    end

    // reset request, level until the system resets this block
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            resetReq_reg <= 1'b0;
        end else if (state_reg == wdt_pkg::ST_PREWARN && warnDone) begin
            resetReq_reg <= 1'b1;
        end
    end
    assign resetReq = resetReq_reg;

    // ****************************************
    // interrupts
    // ****************************************
    always_comb begin
        irqSet = 2'h0;
        irqSet[wdt_pkg::IRQ_PREWARN_BIT] = (state_reg == wdt_pkg::ST_RUN) && coreBus.overflow;
        irqSet[wdt_pkg::IRQ_REFUSED_BIT] = svcWrite && !coreBus.service;
        irqClr = wrHit(wrAccess, paddr, wdt_pkg::OFS_IRQ_CLEAR) ? pwdata[1:0] : 2'h0;
        // a new event wins over a clear in the same cycle
        irqStatus_next = (irqStatus_reg & ~irqClr) | irqSet;
    end

    // sticky status
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            irqStatus_reg <= 2'h0;
        end else begin
            irqStatus_reg <= irqStatus_next;
        end
    end

    // level output while any enabled event is pending
    assign irq = |(irqStatus_reg & irqEnable_reg);

    // ****************************************
    // read path
    // ****************************************
    // captured in the setup phase so data comes from a flop at the access phase
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            prdata_reg <= 32'h00000000;
        end else if (psel && !penable && !pwrite) begin
            case (paddr)
                wdt_pkg::OFS_CTRL: prdata_reg <= {31'h00000000, ratioSlow_reg};
                wdt_pkg::OFS_RELOAD: prdata_reg <= {16'h0000, reloadValue_reg};
                wdt_pkg::OFS_COUNT: prdata_reg <= {14'h0000, resetReq_reg,
                    coreBus.run, coreBus.count};
                wdt_pkg::OFS_IRQ_STATUS: prdata_reg <= {30'h00000000, irqStatus_reg};
                wdt_pkg::OFS_IRQ_ENABLE: prdata_reg <= {30'h00000000, irqEnable_reg};
                default: prdata_reg <= 32'h00000000; // write-only and unmapped
            endcase
        end
    end

    // ****************************************
    // checks
    // ****************************************
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);

    // overflow seen while counting
    sequence sOverflow;
        state_reg == wdt_pkg::ST_RUN && coreBus.overflow;
    endsequence

    // status flag first, request exactly PW_N cycles later
    sequence sWarnThenReset;
        irqStatus_reg[wdt_pkg::IRQ_PREWARN_BIT] && !resetReq_reg ##[PW_N:PW_N] resetReq_reg;
    endsequence

    // reset checks look at the first edge after release
    a_reset_running: assert property ($past(sys_rst) |-> coreBus.run && !resetReq_reg)
        else $error("watchdog not running after reset");
    // instructions act at the write edge itself
    a_disable_stops: assert property (state_reg == wdt_pkg::ST_RUN && disInstr
        && !coreBus.overflow |=> !coreBus.run ##1 !coreBus.tick)
        else $error("disable instruction did not stop the counter");
    a_enable_starts: assert property (state_reg == wdt_pkg::ST_STOP && enInstr && !disInstr
        |=> coreBus.run)
        else $error("enable instruction did not restart the counter");
    // warning time counted from the overflow edge
    a_warn_then_reset: assert property (sOverflow |=> sWarnThenReset)
        else $error("prewarning and reset request out of order or late");
    a_reset_after_warn: assert property ($rose(resetReq_reg)
        |-> $past(state_reg) == wdt_pkg::ST_PREWARN)
        else $error("reset request without prewarning");
    a_default_config: assert property ($past(sys_rst)
        |-> reloadValue_reg == wdt_pkg::RELOAD_RST && ratioSlow_reg == wdt_pkg::RATIO_RST
        && coreBus.count == wdt_pkg::RELOAD_RST)
        else $error("reset configuration wrong");

    // ****************************************
    // checks: stopped counter and late events
    // ****************************************
    // a stopped counter only moves on a service
    a_count_frozen: assert property (state_reg == wdt_pkg::ST_STOP && !coreBus.service
        |=> $stable(coreBus.count))
        else $error("counter moved while stopped");
    // enabled prewarning reaches the pin one cycle after overflow
    a_prewarn_pin: assert property (state_reg == wdt_pkg::ST_RUN && coreBus.overflow
        && irqEnable_reg[wdt_pkg::IRQ_PREWARN_BIT]
        && !wrHit(wrAccess, paddr, wdt_pkg::OFS_IRQ_ENABLE) |=> irq)
        else $error("prewarning interrupt not raised");
    // a late service must neither reload nor pass unnoticed
    a_refused_flag: assert property (svcWrite && (state_reg == wdt_pkg::ST_PREWARN
        || state_reg == wdt_pkg::ST_RESREQ)
        |=> irqStatus_reg[wdt_pkg::IRQ_REFUSED_BIT] && $stable(coreBus.count))
        else $error("refused service not flagged or applied");
    // only a system reset may withdraw the request
    a_request_holds: assert property (resetReq_reg |=> resetReq_reg)
        else $error("reset request withdrawn");

endmodule
